// ==== cpx_pkg.sv ====
// Shared constants and types of the PDO exchange engine
package cpx_pkg;
  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_HZ = 20000000;
  localparam int unsigned MS_PER_S = 1000;
  localparam int unsigned MS_CYC = CLK_HZ / MS_PER_S;
  // Time defaults in milliseconds
  localparam logic [15:0] EVENT_MS_RST = 16'h03E8;
  localparam logic [15:0] INHIBIT_MS_RST = 16'h0064;
  localparam logic [15:0] CYCLIC_MS_RST = 16'h03E8;
  localparam logic [15:0] HB_PROD_MS_RST = 16'h03E8;
  localparam logic [15:0] HB_GUARD_MS_RST = 16'h041A;
  // ----------------------------------------------------------------
  // Sizes and identifiers
  // ----------------------------------------------------------------
  localparam int NPDO = 10;
  localparam logic [3:0] NPDO_L = 4'hA;
  localparam int IMG_WORDS = 40;
  localparam logic [5:0] IMG_N = 6'h28;
  localparam logic [2:0] MAX_WORDS = 3'h4;
  localparam logic [7:0] TT_ASYNC = 8'hFF;
  localparam logic [10:0] COB_180 = 11'h180;
  localparam logic [10:0] COB_200 = 11'h200;
  localparam logic [10:0] COB_HB = 11'h700;
  localparam logic [3:0] HB_DLC = 4'h1;
  localparam logic [7:0] HB_STATE_OPER = 8'h05;
  // ----------------------------------------------------------------
  // Register byte addresses
  // ----------------------------------------------------------------
  localparam logic [11:0] A_CTRL = 12'h000;
  localparam logic [11:0] A_STAT = 12'h004;
  localparam logic [11:0] A_EVT = 12'h008;
  localparam logic [11:0] A_INH = 12'h00C;
  localparam logic [11:0] A_CYC = 12'h010;
  localparam logic [11:0] A_HBP = 12'h014;
  localparam logic [11:0] A_HBG = 12'h018;
  localparam logic [11:0] A_TRIG = 12'h01C;
  localparam logic [11:0] A_HBN = 12'h020;
  localparam logic [11:0] A_TXCFG = 12'h040;
  localparam logic [11:0] A_RXCFG = 12'h080;
  localparam logic [11:0] A_OIMG = 12'h100;
  localparam logic [11:0] A_IIMG = 12'h200;
  localparam int STAT_HBL = 0;
  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [9:0] param_len;
    logic sync_en;
    logic own_dyn;
    logic [6:0] own_node;
  } cpx_ctrl_t;
  typedef struct packed {
    logic [7:0] ttype;
    logic [6:0] slave;
    logic [2:0] size;
    logic dyn;
    logic master;
    logic en;
  } cpx_pdo_cfg_t;
  typedef struct packed {
    logic [10:0] id;
    logic [3:0] dlc;
    logic [63:0] data;
  } cpx_frame_t;
  typedef enum logic [1:0] {
    TX_IDLE = 2'b01,
    TX_BUSY = 2'b10
  } cpx_txst_t;
  localparam cpx_ctrl_t CTRL_RST = '{param_len: 10'h000, sync_en: 1'b0, own_dyn: 1'b0, own_node: 7'h01};
  localparam cpx_pdo_cfg_t CFG_RST = '{ttype: 8'hFF, slave: 7'h00, size: 3'h0, dyn: 1'b0, master: 1'b0, en: 1'b0};
endpackage

// ==== cpx_ms_tick.sv ====
// Millisecond tick prescaler
`timescale 1ns/1ns
module cpx_ms_tick #(
  parameter int unsigned MS_CYCLES = cpx_pkg::MS_CYC
) (
  input wire logic clk_i,
  input wire logic rstn_i,
  output logic tick_o
);
  localparam int CW = $clog2(MS_CYCLES);
  logic [CW-1:0] cnt_q; // Cycles within the current millisecond
  wire wrap = (cnt_q == CW'(MS_CYCLES - 1));

  // Count cycles and pulse once per millisecond
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      cnt_q <= '0;
      tick_o <= 1'b0;
    end else begin
      cnt_q <= wrap ? '0 : cnt_q + 1'b1;
      tick_o <= wrap;
    end
  end
endmodule

// ==== cpx_ms_timer.sv ====
// Millisecond down-counter with reload
`timescale 1ns/1ns
module cpx_ms_timer (
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic tick_i,
  input wire logic load_i,
  input wire logic [15:0] val_i,
  output logic done_o
);
  logic [15:0] cnt_q; // Milliseconds left

  assign done_o = (cnt_q == 16'h0000);

  // Load wins over counting; stops at zero
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      cnt_q <= 16'h0000;
    end else if (load_i) begin
      cnt_q <= val_i;
    end else if (tick_i && !done_o) begin
      cnt_q <= cnt_q - 16'h0001;
    end
  end
endmodule

// ==== cpx_pdo_exchange.sv ====
// PDO exchange engine: Wishbone registers, word images, PDO timing
`timescale 1ns/1ns
module cpx_pdo_exchange #(
  parameter int unsigned MS_CYCLES = cpx_pkg::MS_CYC
) (
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [11:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic [6:0] host_node_i,
  input wire logic rx_valid_i,
  input wire cpx_pkg::cpx_frame_t rx_frame_i,
  output logic tx_valid_o,
  output cpx_pkg::cpx_frame_t tx_frame_o,
  input wire logic tx_ready_i,
  output logic hb_lost_o,
  output logic sync_master_o,
  output logic param_area_en_o
);
  import cpx_pkg::*;

  // ----------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------
  cpx_ctrl_t ctrl_q; // Own node, sync enable, parameter length
  logic [15:0] evt_ms_q; // Event time
  logic [15:0] inh_ms_q; // Inhibit time
  logic [15:0] cyc_ms_q; // Cyclic time
  logic [15:0] hbp_ms_q; // Heartbeat producer time
  logic [15:0] hbg_ms_q; // Heartbeat guard time
  logic [6:0] hb_node_q; // Supervised node
  logic [NPDO-1:0] trig_q; // Application event pulses
  cpx_pdo_cfg_t txcfg_q [NPDO];
  cpx_pdo_cfg_t rxcfg_q [NPDO];
  logic [15:0] oimg_q [IMG_WORDS]; // Output image
  logic [15:0] iimg_q [IMG_WORDS]; // Input image
  logic [6:0] hn_m_q; // Host node, first sync stage
  logic [6:0] hn_s_q; // Host node, synchronised
  logic hb_lost_q;
  logic hb_seen_q;
  logic hb_pend_q;
  logic [NPDO-1:0] pend_q; // Transmit PDO waiting
  cpx_txst_t st_q;
  logic ms_tick;

  // ----------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------
  wire wb_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  wire wr = wb_req & wb_we_i;
  wire [11:0] a = {wb_adr_i[11:2], 2'b00};
  wire [31:0] wmask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
  wire [3:0] cidx = a[5:2]; // Config entry index
  wire [5:0] widx = a[7:2]; // Image word index
  wire hit_tx = (a[11:6] == A_TXCFG[11:6]) && (cidx < NPDO_L);
  wire hit_rx = (a[11:6] == A_RXCFG[11:6]) && (cidx < NPDO_L);
  wire hit_oi = (a[11:8] == A_OIMG[11:8]) && (widx < IMG_N);
  wire hit_ii = (a[11:8] == A_IIMG[11:8]) && (widx < IMG_N);
  wire stat_clr = wr && (a == A_STAT) && wb_sel_i[0] && wb_dat_i[STAT_HBL];

  // ----------------------------------------------------------------
  // Identifiers, sizes and packing
  // ----------------------------------------------------------------
  wire [6:0] own_node = ctrl_q.own_dyn ? hn_s_q : ctrl_q.own_node;
  logic [10:0] txcob [NPDO];
  logic [10:0] rxcob [NPDO];
  logic [2:0] tsz [NPDO];
  logic [2:0] rsz [NPDO];
  logic [5:0] toff [NPDO+1];
  logic [5:0] roff [NPDO+1];
  logic [NPDO-1:0] tx_async;
  logic [NPDO-1:0] tx_cyclic_en;
  logic [NPDO-1:0] per_done;
  logic [NPDO-1:0] inh_done;
  logic [NPDO-1:0] tx_rdy;
  logic [NPDO-1:0] tx_sent;
  logic [NPDO-1:0] rxhit;
  assign toff[0] = 6'h00;
  assign roff[0] = 6'h00;

  function automatic logic [3:0] first_set(input logic [NPDO-1:0] v);
    logic [3:0] r;
    r = 4'h0;
    for (int k = NPDO - 1; k >= 0; k--) begin
      if (v[k]) begin
        r = 4'(k);
      end
    end
    return r;
  endfunction

  wire hb_sent = (st_q == TX_IDLE) && hb_pend_q;
  wire tx_any = |tx_rdy;
  wire [3:0] gsel = first_set(tx_rdy);
  wire pdo_go = (st_q == TX_IDLE) && !hb_pend_q && tx_any;

  for (genvar i = 0; i < NPDO; i++) begin : g_pdo
    wire [6:0] tnode;
    wire [6:0] rnode;
    wire [15:0] per_val;
    assign tnode = txcfg_q[i].dyn ? hn_s_q : txcfg_q[i].slave;
    assign rnode = rxcfg_q[i].dyn ? hn_s_q : rxcfg_q[i].slave;
    assign txcob[i] = (txcfg_q[i].master ? COB_200 : COB_180) + {4'h0, tnode};
    assign rxcob[i] = (rxcfg_q[i].master ? COB_180 : COB_200) + {4'h0, rnode};
    // at most four words per PDO
    assign tsz[i] = (txcfg_q[i].size > MAX_WORDS) ? MAX_WORDS : txcfg_q[i].size;
    assign rsz[i] = (rxcfg_q[i].size > MAX_WORDS) ? MAX_WORDS : rxcfg_q[i].size;
    assign toff[i+1] = toff[i] + {3'h0, tsz[i]};
    assign roff[i+1] = roff[i] + {3'h0, rsz[i]};
    assign tx_async[i] = (txcfg_q[i].ttype == TT_ASYNC);
    assign tx_cyclic_en[i] = txcfg_q[i].en && !tx_async[i];
    // cyclic time only in cyclic type
    assign per_val = tx_async[i] ? evt_ms_q : cyc_ms_q;
    assign tx_sent[i] = pdo_go && (gsel == 4'(i));
    assign tx_rdy[i] = pend_q[i] && txcfg_q[i].en && (inh_done[i] || !tx_async[i]);
    assign rxhit[i] = rx_valid_i && rxcfg_q[i].en && (rxcob[i] == rx_frame_i.id);

    cpx_ms_timer u_per (
      .clk_i(clk_i),
      .rstn_i(rstn_i),
      .tick_i(ms_tick),
      .load_i(tx_sent[i] || !txcfg_q[i].en),
      .val_i(per_val),
      .done_o(per_done[i])
    );
    cpx_ms_timer u_inh (
      .clk_i(clk_i),
      .rstn_i(rstn_i),
      .tick_i(ms_tick),
      .load_i(tx_sent[i]),
      .val_i(inh_ms_q),
      .done_o(inh_done[i])
    );

    // Configuration registers, byte-lane writes
    always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
        txcfg_q[i] <= CFG_RST;
        rxcfg_q[i] <= CFG_RST;
      end else if (wr && cidx == 4'(i)) begin
        if (hit_tx) begin
          txcfg_q[i] <= cpx_pdo_cfg_t'((txcfg_q[i] & ~wmask[20:0]) | (wb_dat_i[20:0] & wmask[20:0]));
        end
        if (hit_rx) begin
          rxcfg_q[i] <= cpx_pdo_cfg_t'((rxcfg_q[i] & ~wmask[20:0]) | (wb_dat_i[20:0] & wmask[20:0]));
        end
      end
    end

    // pending on event or period; an event set beats send, a period set does not
    always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
        pend_q[i] <= 1'b0;
      end else begin
        pend_q[i] <= txcfg_q[i].en && ((pend_q[i] && !tx_sent[i]) || (tx_async[i] && trig_q[i])
                     || (per_done[i] && !tx_sent[i] && per_val != 16'h0000));
      end
    end
  end

  // ----------------------------------------------------------------
  // Transmit payload assembly
  // ----------------------------------------------------------------
  wire [5:0] tbase = toff[gsel];
  wire [2:0] tsize = tsz[gsel];
  logic [15:0] tword [4];
  for (genvar k = 0; k < 4; k++) begin : g_tw
    wire [5:0] ti = tbase + 6'(k);
    assign tword[k] = ((3'(k) < tsize) && (ti < IMG_N)) ? oimg_q[ti] : 16'h0000;
  end

  // ----------------------------------------------------------------
  // Receive matching
  // ----------------------------------------------------------------
  // unmatched identifiers leave the image alone
  wire rx_any = |rxhit;
  wire [3:0] rsel = first_set(rxhit);
  wire [5:0] rbase = roff[rsel];
  wire [5:0] rend = rbase + {3'h0, rsz[rsel]};
  wire hb_rx = rx_valid_i && (rx_frame_i.id == (COB_HB + {4'h0, hb_node_q}));

  for (genvar j = 0; j < IMG_WORDS; j++) begin : g_img
    wire [5:0] rel = 6'(j) - rbase;
    wire rin = rx_any && (6'(j) >= rbase) && (6'(j) < rend);
    // Output image written by software
    always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
        oimg_q[j] <= 16'h0000;
      end else if (wr && hit_oi && widx == 6'(j)) begin
        oimg_q[j] <= (oimg_q[j] & ~wmask[15:0]) | (wb_dat_i[15:0] & wmask[15:0]);
      end
    end
    always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
        iimg_q[j] <= 16'h0000;
      end else if (rin) begin
        iimg_q[j] <= rx_frame_i.data[{rel[1:0], 4'h0} +: 16];
      end
    end
  end

  // ----------------------------------------------------------------
  // Heartbeat timers
  // ----------------------------------------------------------------
  logic hbp_done;
  logic hbg_done;
  cpx_ms_tick #(.MS_CYCLES(MS_CYCLES)) u_tick (
    .clk_i(clk_i),
    .rstn_i(rstn_i),
    .tick_o(ms_tick)
  );
  cpx_ms_timer u_hbp (
    .clk_i(clk_i),
    .rstn_i(rstn_i),
    .tick_i(ms_tick),
    .load_i(hb_sent),
    .val_i(hbp_ms_q),
    .done_o(hbp_done)
  );
  cpx_ms_timer u_hbg (
    .clk_i(clk_i),
    .rstn_i(rstn_i),
    .tick_i(ms_tick),
    .load_i(hb_rx || hbg_done),
    .val_i(hbg_ms_q),
    .done_o(hbg_done)
  );
  wire hb_miss = hbg_done && hb_seen_q && !hb_rx && (hbg_ms_q != 16'h0000);

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      hb_pend_q <= 1'b0;
    end else begin
      hb_pend_q <= (hb_pend_q && !hb_sent) || (hbp_done && !hb_sent && hbp_ms_q != 16'h0000);
    end
  end

  // guard expiry sets sticky loss flag
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      hb_seen_q <= 1'b0;
      hb_lost_q <= 1'b0;
    end else begin
      hb_seen_q <= hb_seen_q || hb_rx;
      hb_lost_q <= (hb_lost_q && !stat_clr) || hb_miss;
    end
  end

  // ----------------------------------------------------------------
  // Transmit sequencer
  // ----------------------------------------------------------------
  // Heartbeat first, then lowest ready PDO
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      st_q <= TX_IDLE;
      tx_valid_o <= 1'b0;
      tx_frame_o <= '0;
    end else begin
      case (st_q)
        TX_IDLE: begin
          if (hb_sent) begin
            st_q <= TX_BUSY;
            tx_valid_o <= 1'b1;
            tx_frame_o <= '{id: COB_HB + {4'h0, own_node}, dlc: HB_DLC, data: {56'h0, HB_STATE_OPER}};
          end else if (pdo_go) begin
            st_q <= TX_BUSY;
            tx_valid_o <= 1'b1;
            // payload bytes are twice the words
            tx_frame_o <= '{id: txcob[gsel], dlc: {tsize, 1'b0}, data: {tword[3], tword[2], tword[1], tword[0]}};
          end
        end
        TX_BUSY: begin
          if (tx_ready_i) begin
            st_q <= TX_IDLE;
            tx_valid_o <= 1'b0;
          end
        end
        default: begin
          st_q <= TX_IDLE;
          tx_valid_o <= 1'b0;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Global registers and status outputs
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      ctrl_q <= CTRL_RST;
      evt_ms_q <= EVENT_MS_RST;
      inh_ms_q <= INHIBIT_MS_RST;
      cyc_ms_q <= CYCLIC_MS_RST;
      hbp_ms_q <= HB_PROD_MS_RST;
      hbg_ms_q <= HB_GUARD_MS_RST;
      hb_node_q <= 7'h00;
    end else if (wr) begin
      if (a == A_CTRL) ctrl_q <= cpx_ctrl_t'((ctrl_q & ~wmask[18:0]) | (wb_dat_i[18:0] & wmask[18:0]));
      if (a == A_EVT) evt_ms_q <= (evt_ms_q & ~wmask[15:0]) | (wb_dat_i[15:0] & wmask[15:0]);
      if (a == A_INH) inh_ms_q <= (inh_ms_q & ~wmask[15:0]) | (wb_dat_i[15:0] & wmask[15:0]);
      if (a == A_CYC) cyc_ms_q <= (cyc_ms_q & ~wmask[15:0]) | (wb_dat_i[15:0] & wmask[15:0]);
      if (a == A_HBP) hbp_ms_q <= (hbp_ms_q & ~wmask[15:0]) | (wb_dat_i[15:0] & wmask[15:0]);
      if (a == A_HBG) hbg_ms_q <= (hbg_ms_q & ~wmask[15:0]) | (wb_dat_i[15:0] & wmask[15:0]);
      if (a == A_HBN && wb_sel_i[0]) hb_node_q <= wb_dat_i[6:0];
    end
  end

  // Event triggers are one-cycle pulses; host node passes two stages
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      trig_q <= '0;
      hn_m_q <= 7'h00;
      hn_s_q <= 7'h00;
    end else begin
      trig_q <= (wr && a == A_TRIG) ? (wb_dat_i[NPDO-1:0] & {wmask[9:8], wmask[7:0]}) : '0;
      hn_m_q <= host_node_i;
      hn_s_q <= hn_m_q;
    end
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      hb_lost_o <= 1'b0;
      sync_master_o <= 1'b0;
      param_area_en_o <= 1'b0;
    end else begin
      hb_lost_o <= hb_lost_q;
      sync_master_o <= ctrl_q.sync_en && (|tx_cyclic_en);
      param_area_en_o <= (ctrl_q.param_len != 10'h000);
    end
  end

  // ----------------------------------------------------------------
  // Wishbone answer
  // ----------------------------------------------------------------
  wire [31:0] rd_data =
    (a == A_CTRL) ? 32'(ctrl_q) :
    (a == A_STAT) ? {29'h0, param_area_en_o, sync_master_o, hb_lost_q} :
    (a == A_EVT) ? {16'h0, evt_ms_q} :
    (a == A_INH) ? {16'h0, inh_ms_q} :
    (a == A_CYC) ? {16'h0, cyc_ms_q} :
    (a == A_HBP) ? {16'h0, hbp_ms_q} :
    (a == A_HBG) ? {16'h0, hbg_ms_q} :
    (a == A_HBN) ? {25'h0, hb_node_q} :
    hit_tx ? 32'(txcfg_q[cidx]) :
    hit_rx ? 32'(rxcfg_q[cidx]) :
    hit_oi ? {16'h0, oimg_q[widx]} :
    hit_ii ? {16'h0, iimg_q[widx]} : 32'h0000_0000;

  // One-cycle acknowledge for every address
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= wb_req;
      wb_dat_o <= wb_req ? rd_data : 32'h0000_0000;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rstn_i);

  property p_dlc;
    $rose(tx_valid_o) && !$past(hb_pend_q) |-> tx_frame_o.dlc == {$past(tsize), 1'b0};
  endproperty
  a_dlc: assert property (p_dlc) else $error("PDO length not twice its words");
  property p_inh;
    tx_sent[0] && tx_async[0] && (inh_ms_q != 16'h0000) |=> !inh_done[0] && !(tx_rdy[0] && tx_async[0]);
  endproperty
  a_inh: assert property (p_inh) else $error("PDO sent inside inhibit time");
  property p_evt;
    $rose(pend_q[0]) && tx_async[0] |-> $past(trig_q[0]) || $past(per_done[0]);
  endproperty
  a_evt: assert property (p_evt) else $error("Async PDO pending without cause");
  property p_cob;
    txcfg_q[0].master && !txcfg_q[0].dyn |-> txcob[0] == COB_200 + {4'h0, txcfg_q[0].slave};
  endproperty
  a_cob: assert property (p_cob) else $error("Master transmit identifier wrong");
  property p_rxig;
    rx_valid_i && !rx_any |=> $stable(iimg_q[0]) && $stable(iimg_q[IMG_WORDS-1]);
  endproperty
  a_rxig: assert property (p_rxig) else $error("Unmatched frame changed input image");
  property p_lost;
    hb_miss |=> hb_lost_q ##1 hb_lost_o;
  endproperty
  a_lost: assert property (p_lost) else $error("Heartbeat loss not flagged");
  property p_sync;
    !(|tx_cyclic_en) |=> !sync_master_o;
  endproperty
  a_sync: assert property (p_sync) else $error("Sync master active with async PDOs");
  property p_parm;
    ctrl_q.param_len == 10'h000 |=> !param_area_en_o;
  endproperty
  a_parm: assert property (p_parm) else $error("Parameter area enabled at length zero");
  property p_hb;
    hb_sent |=> tx_valid_o && tx_frame_o.id == COB_HB + {4'h0, $past(own_node)};
  endproperty
  a_hb: assert property (p_hb) else $error("Heartbeat frame not issued");
endmodule

// ==== cpx_remote_node.sv ====
// Remote node model on the far side of the frame links
`timescale 1ns/1ns
module cpx_remote_node (
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic tx_valid_i,
  input wire cpx_pkg::cpx_frame_t tx_frame_i,
  output logic tx_ready_o,
  output logic rx_valid_o,
  output cpx_pkg::cpx_frame_t rx_frame_o,
  output logic got_o,
  output cpx_pkg::cpx_frame_t got_frame_o
);
  import cpx_pkg::*;
  int s = 11;
  // Receive lines start idle; only the send task drives them afterwards
  initial begin
    {rx_valid_o, rx_frame_o} = '0;
  end
  // Takes frames with random stalls, reports each one taken
  always @(posedge clk_i) begin
    if (!rstn_i) begin
      got_o <= 1'b0;
      tx_ready_o <= 1'b0;
    end else begin
      got_o <= tx_valid_i && tx_ready_o;
      tx_ready_o <= ($random(s) % 3 != 0);
    end
    got_frame_o <= tx_frame_i;
  end
  // One frame for one cycle; the lines then show the inverse
  task automatic send(input logic [10:0] id, input logic [3:0] dlc, input logic [63:0] d);
    @(posedge clk_i);
    rx_valid_o <= 1'b1;
    rx_frame_o <= '{id: id, dlc: dlc, data: d};
    @(posedge clk_i);
    rx_valid_o <= 1'b0;
    rx_frame_o <= ~rx_frame_o;
  endtask
  task automatic send_hb(input logic [6:0] node);
    send(COB_HB + 11'(node), HB_DLC, 64'(HB_STATE_OPER));
  endtask
endmodule

// ==== cpx_pdo_exchange_tb.sv ====
// Bench of the PDO engine against a remote node model
`timescale 1ns/1ns
module cpx_pdo_exchange_tb;
  import cpx_pkg::*;
  localparam int MS = 20;
  logic clk_i = 1'b0, rstn_i = 1'b0, cyc = 1'b0, we = 1'b0, ack, rxv, txv, rdy, lost, syncm, parm, got;
  logic [3:0] sel = 4'h0;
  logic [11:0] adr = 12'h000;
  logic [31:0] wd = 32'h0, rdat, q;
  logic [6:0] host_node = 7'h05;
  logic [63:0] d;
  logic [10:0] exp_id = 11'h000;
  cpx_frame_t rxf, txf, gotf;
  cpx_pdo_cfg_t cfg;
  int n_fail = 0, n_tests = 0, seed = 11, cyc_n = 0, last = -1, hb_last = -1, nhb = 0;
  int inh = 0, evt = 0, size_m = 0, npdo = 0, n0;
  int oimg [4];
  cpx_pdo_exchange #(.MS_CYCLES(MS)) uut (.clk_i(clk_i), .rstn_i(rstn_i), .wb_cyc_i(cyc), .wb_stb_i(cyc),
    .wb_we_i(we), .wb_sel_i(sel), .wb_adr_i(adr), .wb_dat_i(wd), .wb_dat_o(rdat), .wb_ack_o(ack),
    .host_node_i(host_node), .rx_valid_i(rxv), .rx_frame_i(rxf), .tx_valid_o(txv), .tx_frame_o(txf),
    .tx_ready_i(rdy), .hb_lost_o(lost), .sync_master_o(syncm), .param_area_en_o(parm));
  cpx_remote_node u_node (.clk_i(clk_i), .rstn_i(rstn_i), .tx_valid_i(txv), .tx_frame_i(txf),
    .tx_ready_o(rdy), .rx_valid_o(rxv), .rx_frame_o(rxf), .got_o(got), .got_frame_o(gotf));
  initial begin
    forever #25 clk_i = ~clk_i;
  end
  task chk(input string nm, input logic [63:0] seen, input logic [63:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_fail++;
      $display("mismatch %s expected %0h seen %0h", nm, exp, seen);
    end
  endtask
  task print_verdict;
    $display("checks %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // Classic Wishbone cycle, held until ack is sampled
  task wb(input logic w, input logic [11:0] a, input logic [31:0] dat);
    @(posedge clk_i);
    cyc <= 1'b1; we <= w; adr <= a; wd <= dat; sel <= 4'hF;
    do @(posedge clk_i); while (ack !== 1'b1);
    q = rdat;
    cyc <= 1'b0; we <= 1'b0;
  endtask
  task rd(input logic [11:0] a, input logic [31:0] e);
    wb(1'b0, a, 32'h0);
    chk("register", q, e);
  endtask
  // Every frame taken by the remote node is checked against the model
  always @(posedge clk_i) begin
    cyc_n++;
    if (cyc_n == 40000) begin
      n_fail++;
      print_verdict();
    end
    if (got && gotf.id == COB_HB + 11'h001) begin
      chk("hb frame", {gotf.dlc, gotf.data[7:0]}, {HB_DLC, HB_STATE_OPER});
      if (hb_last >= 0) chk("hb period", cyc_n - hb_last > 998 * MS && cyc_n - hb_last < 1001 * MS, 1);
      hb_last = cyc_n;
      nhb++;
    end else if (got) begin
      npdo++;
      chk("tx id", gotf.id, exp_id);
      chk("tx dlc", gotf.dlc, 2 * size_m);
      for (int k = 0; k < size_m; k++) chk("tx word", gotf.data[16*k+:16], oimg[k]);
      if (inh > 0 && last >= 0) chk("inhibit gap", cyc_n - last >= (inh - 1) * MS, 1);
      if (evt > 0 && last >= 0) chk("event gap", cyc_n - last <= (evt + 1) * MS + 8, 1);
      last = cyc_n;
    end
  end
  initial begin
    repeat (6) @(posedge clk_i);
    rstn_i <= 1'b1;
    rd(A_CTRL, 32'h0000_0001);
    rd(A_EVT, 32'h0000_03E8);
    rd(A_INH, 32'h0000_0064);
    rd(A_HBG, 32'h0000_041A);
    rd(A_IIMG + 12'h0A0, 32'h0);
    wb(1'b1, A_EVT, 32'h0);
    wb(1'b1, A_INH, 32'h3);
    wb(1'b1, A_CYC, 32'h1);
    for (int k = 0; k < 4; k++) begin
      oimg[k] = $random(seed) & 16'hFFFF;
      wb(1'b1, A_OIMG + 12'(4 * k), 32'(oimg[k]));
    end
    for (int c = 0; c < 3; c++) begin
      cfg = '{ttype: TT_ASYNC, slave: 7'h02, size: 3'(c + 2), dyn: c == 2, master: c != 1, en: 1'b1};
      exp_id = (c != 1 ? COB_200 : COB_180) + (c == 2 ? 11'(host_node) : 11'h002);
      size_m = c + 2;
      wb(1'b1, A_TXCFG, 32'(cfg));
      repeat (100) @(posedge clk_i);
      n0 = npdo;
      wb(1'b1, A_TRIG, 32'h1);
      for (int i = 0; i < 400 && npdo == n0; i++) @(posedge clk_i);
      chk("triggered pdo", npdo - n0, 1);
    end
    n0 = npdo;
    repeat (200) @(posedge clk_i);
    chk("no unprompted pdo", npdo - n0, 0);
    wb(1'b1, A_EVT, 32'h6);
    repeat (150) @(posedge clk_i);
    last = -1; inh = 3; evt = 6; n0 = npdo;
    wb(1'b1, A_TRIG, 32'h1);
    wb(1'b1, A_TRIG, 32'h1);
    repeat (600) @(posedge clk_i);
    chk("event resends", npdo - n0 >= 4, 1);
    inh = 0; evt = 0;
    wb(1'b1, A_EVT, 32'h0);
    wb(1'b1, A_CTRL, 32'h0000_0101);
    repeat (3) @(posedge clk_i);
    chk("sync off", {syncm, parm}, 2'b00);
    cfg.ttype = 8'h00;
    wb(1'b1, A_TXCFG, 32'(cfg));
    wb(1'b1, A_CTRL, 32'h0000_0B01);
    n0 = npdo;
    repeat (100) @(posedge clk_i);
    chk("sync and param on", {syncm, parm}, 2'b11);
    chk("cyclic sends", npdo - n0 >= 3, 1);
    cfg = '{ttype: TT_ASYNC, slave: 7'h02, size: 3'h3, dyn: 1'b0, master: 1'b1, en: 1'b1};
    wb(1'b1, A_RXCFG, 32'(cfg));
    d = {$random(seed), $random(seed)};
    u_node.send(COB_180 + 11'h002, 4'h8, d);
    for (int k = 0; k < 4; k++) rd(A_IIMG + 12'(4 * k), k < 3 ? 32'(d[16*k+:16]) : 32'h0);
    u_node.send(COB_180 + 11'h003, 4'h8, ~d);
    rd(A_IIMG, 32'(d[15:0]));
    wb(1'b1, A_HBG, 32'h4);
    wb(1'b1, A_HBN, 32'h2);
    u_node.send_hb(7'h02);
    repeat (40) @(posedge clk_i);
    chk("hb lost early", lost, 1'b0);
    repeat (80) @(posedge clk_i);
    chk("hb lost", lost, 1'b1);
    repeat (20100) @(posedge clk_i);
    chk("hb count", nhb >= 2, 1);
    print_verdict();
  end
endmodule
